/* File: verilog/txdsw_top.sv */
// Transmit descriptor handling with status and reflectometry write-back
`default_nettype none
module txdsw_top
	import txdsw_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Descriptor from host memory
	input wire logic desc_valid,
	input wire logic [15:0] desc_count_word,
	input wire logic desc_own,
	input wire logic desc_end_of_frame,
	input wire logic disable_retry_bit,
	input wire logic aui_mode,
	// Network side pins
	input wire logic collision_pin,
	input wire logic carrier_pin,
	input wire logic slot_elapsed_pin,
	// Byte transmit strobe and acknowledge
	output logic tx_byte_req,
	input wire logic tx_byte_ack,
	// Status write-back
	output logic desc_taken,
	output logic status_we,
	output logic [15:0] status_word,
	output logic [15:0] refl_word
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {slot_elapsed_pin, carrier_pin, collision_pin};
			sync2_r <= sync1_r;
		end
	end
	wire coll_s = sync2_r[0];
	wire carr_s = sync2_r[1];
	wire slot_s = sync2_r[2];

	// ****************************************
	// State and counters
	// ****************************************
	txdsw_state_type state_r, state_nxt;
	logic [CNT_FIELD_W-1:0] left_r;
	logic [CNT_FIELD_W-1:0] len_r;
	logic [1:0] tries_r;
	logic late_coll_r;
	logic carr_lost_r;
	logic retry_err_r;
	logic frozen_r;
	logic [REFL_W-1:0] refl_r;
	logic [7:0] div_r;
	logic req_r;
	logic taken_r;
	logic we_r;
	logic [15:0] stat_r;
	logic [15:0] reflw_r;

	// ****************************************
	// Decode
	// ****************************************
	// Length is the negated two's complement count; the field itself is never written
	// Exact byte count
	wire [CNT_FIELD_W-1:0] len_w = CNT_FIELD_W'(~desc_count_word[CNT_FIELD_W-1:0] + 1'b1);
	wire accept_w = desc_valid && desc_own && (state_r == ST_IDLE);
	wire sending_w = (state_r == ST_SEND);
	wire refl_tick_w = (div_r == 8'(REFL_DIV - 1));
	// Early collision retries, late one aborts retry
	wire coll_ev_w = sending_w && coll_s;
	wire late_w = coll_ev_w && slot_s;
	wire lost_w = sending_w && aui_mode && !carr_s;
	wire last_byte_w = sending_w && tx_byte_ack && (left_r == 12'h001);
	// Retry exhaustion
	// A fixed retry limit keeps a jammed line from holding the descriptor forever
	wire give_up_w = (disable_retry_bit || tries_r == MAX_TRIES);
	wire fail_w = coll_ev_w && (late_w || give_up_w);
	wire retry_w = coll_ev_w && !fail_w;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (accept_w) state_nxt = ST_LOAD;
			ST_LOAD: state_nxt = (len_r == 12'h000) ? ST_DONE : ST_SEND;
			// Carrier loss does not stop sending
			ST_SEND: begin
				if (fail_w || last_byte_w) state_nxt = ST_DONE;
				else if (retry_w) state_nxt = ST_LOAD;
			end
			ST_DONE: state_nxt = ST_WAIT;
			ST_WAIT: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			len_r <= 12'h000;
			left_r <= 12'h000;
			tries_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if (accept_w) len_r <= len_w;
			if (accept_w) tries_r <= 2'h0;
			else if (retry_w) tries_r <= tries_r + 2'h1;
			if (state_r == ST_LOAD) left_r <= len_r;
			else if (sending_w && tx_byte_ack) left_r <= left_r - 12'h001;
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// Flags clear per frame; only set here during the frame
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			late_coll_r <= 1'b0;
			carr_lost_r <= 1'b0;
			retry_err_r <= 1'b0;
		end else if (accept_w) begin
			late_coll_r <= 1'b0;
			carr_lost_r <= 1'b0;
			retry_err_r <= 1'b0;
		end else begin
			if (late_w) late_coll_r <= 1'b1;
			if (lost_w) carr_lost_r <= 1'b1;
			if (fail_w && !late_w) retry_err_r <= 1'b1;
		end
	end

	// ****************************************
	// Reflectometry counter
	// ****************************************
	// Only 10 MHz resolution, so it gives a coarse fault distance at best
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			refl_r <= 10'h000;
			div_r <= 8'h00;
			frozen_r <= 1'b0;
		end else if (state_r == ST_LOAD) begin
			refl_r <= 10'h000;
			div_r <= 8'h00;
			frozen_r <= 1'b0;
		end else if (sending_w && !frozen_r) begin
			div_r <= refl_tick_w ? 8'h00 : div_r + 8'h01;
			if (refl_tick_w) refl_r <= refl_r + 10'h001;
			if (coll_ev_w || lost_w) frozen_r <= 1'b1;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Status word assembled from the named field positions
	logic [15:0] stat_w;
	always_comb begin
		stat_w = STAT_RST;
		stat_w[OWN_POS] = 1'b0;
		stat_w[RSV_POS] = 1'b0;
		stat_w[LATE_POS] = late_coll_r;
		stat_w[CARR_POS] = carr_lost_r;
		stat_w[RETRY_POS] = retry_err_r;
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			req_r <= 1'b0;
			taken_r <= 1'b0;
			we_r <= 1'b0;
			stat_r <= STAT_RST;
			reflw_r <= STAT_RST;
		end else begin
			req_r <= (state_nxt == ST_SEND) && !(sending_w && tx_byte_ack && left_r == 12'h001);
			taken_r <= accept_w;
			we_r <= (state_r == ST_DONE);
			if (state_r == ST_DONE) begin
				stat_r <= stat_w;
				reflw_r <= {6'h00, refl_r};
			end
		end
	end
	assign tx_byte_req = req_r;
	assign desc_taken = taken_r;
	assign status_we = we_r;
	assign status_word = stat_r;
	assign refl_word = reflw_r;
	// Upper fill field is only read, never returned
	wire unused_w = &{1'b0, desc_count_word[FILL_HI:FILL_LO], desc_end_of_frame};
endmodule : txdsw_top
`default_nettype wire

/* File: shared/txdsw_pkg.sv */
// Package: constants and types for the transmit descriptor status write-back block
`default_nettype none
package txdsw_pkg;
	// ****************************************
	// Descriptor word fields
	// ****************************************
	localparam int CNT_FIELD_W = 12;
	localparam int FILL_HI = 15;
	localparam int FILL_LO = 12;
	localparam logic [3:0] FILL_VAL = 4'hF;
	localparam int OWN_POS = 15;
	localparam int RSV_POS = 0;
	localparam int LATE_POS = 12;
	localparam int CARR_POS = 11;
	localparam int RETRY_POS = 10;
	localparam int REFL_W = 10;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int REFL_HZ = 10000000;
	localparam int REFL_DIV = (CLK_HZ / REFL_HZ < 1) ? 1 : CLK_HZ / REFL_HZ;
	localparam logic [1:0] MAX_TRIES = 2'h3;
	localparam logic [15:0] STAT_RST = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_SEND = 3'b010,
		ST_WAIT = 3'b011,
		ST_DONE = 3'b100
	} txdsw_state_type;
endpackage : txdsw_pkg
`default_nettype wire

/* File: tb/txdsw_top_sva.sv */
// Port checker for the descriptor block
`default_nettype none
module txdsw_top_sva (
	// Clocking
	input wire logic clk_sys,
	input wire logic resetn,
	// Watched ports
	input wire logic desc_valid,
	input wire logic desc_own,
	input wire logic [15:0] desc_count_word,
	input wire logic tx_byte_req,
	input wire logic desc_taken,
	input wire logic status_we,
	input wire logic [15:0] status_word,
	input wire logic [15:0] refl_word
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ****
	// Assertions
	// ****
	a_take_owned:
	assert property (desc_taken |-> $past(desc_valid && desc_own) ##1 !desc_taken)
		else $error("take without ownership");
	a_status_pulse:
	assert property (status_we |-> !tx_byte_req ##1 !status_we)
		else $error("write-back not a lone pulse");
	a_res_own_zero:
	assert property (status_we |-> !status_word[0] && !status_word[15])
		else $error("reserved or own bit set");
	a_refl_width:
	assert property (status_we |-> refl_word[15:10] == 6'h00)
		else $error("count field too wide");
	a_late_final:
	assert property (status_we && status_word[12] |-> !status_word[10])
		else $error("late collision retried");
	a_flags_held:
	assert property (!status_we |-> $stable(status_word) && $stable(refl_word))
		else $error("status moved outside write-back");
	a_send_start:
	assert property (desc_taken && $past(desc_count_word[11:0]) != 12'h000 |=> tx_byte_req)
		else $error("no byte request");
	a_zero_len:
	assert property (desc_taken && $past(desc_count_word[11:0]) == 12'h000
		|-> !tx_byte_req [*2] ##1 status_we)
		else $error("zero length mishandled");
endmodule : txdsw_top_sva
bind txdsw_top txdsw_top_sva txdsw_top_sva_i (.clk_sys, .resetn, .desc_valid, .desc_own,
	.desc_count_word, .tx_byte_req, .desc_taken, .status_we, .status_word, .refl_word);
`default_nettype wire

/* File: tb/txdsw_host_mem.sv */
// Host memory model serving one descriptor and taking bytes
`default_nettype none
module txdsw_host_mem
	import txdsw_pkg::*;
(
	// Bench control
	input wire logic clk_sys,
	input wire logic go,
	input wire logic slow,
	input wire logic [11:0] len,
	// Block side
	input wire logic desc_taken,
	input wire logic tx_byte_req,
	output logic desc_valid,
	output logic desc_own,
	output logic [15:0] desc_count_word,
	output logic tx_byte_ack,
	output logic [11:0] sent
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tick;
	logic [15:0] word;
	assign word = {FILL_VAL, 12'h000 - len};
	// Released word is inverted so stale data never looks valid
	assign desc_count_word = desc_valid ? word : ~word;
	assign desc_own = desc_valid;
	assign tx_byte_ack = tx_byte_req && (!slow || tick);
	initial begin
		tick = 1'b0;
		desc_valid = 1'b0;
		sent = 12'h000;
	end
	always @(posedge clk_sys) begin
		tick <= ~tick;
		desc_valid <= go || (desc_valid && !desc_taken);
		sent <= desc_taken ? 12'h000 : sent + 12'(tx_byte_ack);
	end
endmodule : txdsw_host_mem
`default_nettype wire

/* File: tb/test_txdsw_top.sv */
// Bench for the descriptor block
`default_nettype none
module test_txdsw_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, resetn = 1'b0, go = 1'b0, slow = 1'b0;
	logic disable_retry_bit = 1'b0, aui_mode = 1'b0, carrier_pin = 1'b1;
	logic collision_pin = 1'b0, slot_elapsed_pin = 1'b0;
	logic [11:0] len = 12'h000;
	logic [11:0] sent;
	logic desc_valid, desc_own, tx_byte_req, tx_byte_ack, desc_taken, status_we;
	logic [15:0] desc_count_word, status_word, refl_word;
	int bad_count = 0, checked = 0;
	txdsw_top txdsw_top_i (.clk_sys, .resetn, .desc_valid, .desc_count_word, .desc_own,
		.desc_end_of_frame(1'b1), .disable_retry_bit, .aui_mode, .collision_pin,
		.carrier_pin, .slot_elapsed_pin, .tx_byte_req, .tx_byte_ack, .desc_taken,
		.status_we, .status_word, .refl_word);
	txdsw_host_mem txdsw_host_mem_i (.clk_sys, .go, .slow, .len, .desc_taken,
		.tx_byte_req, .desc_valid, .desc_own, .desc_count_word, .tx_byte_ack, .sent);
	initial forever #50 clk_sys = ~clk_sys;
	// ****
	// Tasks
	// ****
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Line events sit in cycles 8 to 11, inside the send phase of a 40 byte frame
	// Modes: 0 clean, 1 late collision, 2 no retry, 3 AUI carrier loss, 4 loss off AUI, 5 retries
	task automatic frame(input logic [11:0] n, input logic s, input int m, input logic [15:0] e);
		int k = 0;
		logic ev;
		@(posedge clk_sys);
		len <= n;
		slow <= s;
		go <= 1'b1;
		disable_retry_bit <= (m == 2);
		aui_mode <= (m == 3);
		do begin
			@(posedge clk_sys);
			k++;
			ev = k > 7 && k < 12;
			go <= 1'b0;
			collision_pin <= ev && (m == 1 || m == 2 || m == 5);
			slot_elapsed_pin <= ev && m == 1;
			carrier_pin <= !(ev && (m == 3 || m == 4));
			@(negedge clk_sys);
		end while (status_we !== 1'b1 && k < 9000);
		// A frame that never writes back counts as a mismatch here
		chk({15'h0000, status_we}, 16'h0001);
		chk(status_word, e);
		if (m == 0 || m == 3 || m == 4) begin
			chk({4'h0, sent}, {4'h0, n});
		end
		// Collision seen 8 cycles into sending, after the two-stage pin lag
		if (m == 2) begin
			chk(refl_word, 16'h0008);
		end
		// Two early collisions retry; the last attempt counts one tick per byte from zero
		if (m == 5) begin
			chk(refl_word, {4'h0, n});
		end
		$display("test mode %0d length %0d done", m, n);
	endtask : frame
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		frame(12'h005, 1'b0, 0, 16'h0000);
		frame(12'h000, 1'b0, 0, 16'h0000);
		frame(12'hFFF, 1'b1, 0, 16'h0000);
		frame(12'h028, 1'b0, 1, 16'h1000);
		frame(12'h028, 1'b0, 2, 16'h0400);
		frame(12'h028, 1'b1, 3, 16'h0800);
		frame(12'h028, 1'b0, 4, 16'h0000);
		frame(12'h028, 1'b0, 5, 16'h0000);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		end_of_test();
	end
endmodule : test_txdsw_top
`default_nettype wire
